// >>> dse_pkg.sv
// constants for the diagnostic status encoder
package dse_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  // flash timing in milliseconds
  localparam int unsigned FLASH_ON_MS     = 200;
  localparam int unsigned FLASH_OFF_MS    = 200;
  localparam int unsigned BURST_PAUSE_MS  = 1000;
  localparam int unsigned INHIBIT_MIN     = 10;
  localparam int unsigned FLASH_ON_CYC    = (CLK_HZ / 1000) * FLASH_ON_MS;
  localparam int unsigned FLASH_OFF_CYC   = (CLK_HZ / 1000) * FLASH_OFF_MS;
  localparam int unsigned PAUSE_CYC       = (CLK_HZ / 1000) * BURST_PAUSE_MS;
  localparam longint unsigned INHIBIT_CYC = 64'(CLK_HZ) * 64'(60 * INHIBIT_MIN);
  // yellow flash code pulse counts
  localparam logic [2:0] CODE_TEMP_PULSES = 3'h4;
  localparam logic [2:0] CODE_ACT_PULSES  = 3'h5;
  // bus led encoding {red, green}
  localparam logic [1:0] LED_OFF   = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_RED   = 2'h2;
  // safety code static value
  localparam logic [3:0] CODE_STATIC_ZERO = 4'h0;
  // parameter write value that requests diagnostics
  localparam logic [3:0] PARAM_READ_CMD = 4'hf;
  // parameter bit positions, standard variant
  localparam int unsigned PB_ACT_IN  = 0;
  localparam int unsigned PB_HYST    = 1;
  localparam int unsigned PB_INHIBIT = 2;
  localparam int unsigned PB_INT_ERR = 3;
  // indication states
  typedef enum logic [4:0] {
    ST_OPEN    = 5'h01,
    ST_CLOSED  = 5'h02,
    ST_HYST    = 5'h04,
    ST_INHIBIT = 5'h08,
    ST_FAULT   = 5'h10
  } dse_state_e;
endpackage

// >>> dse_flasher.sv
// flash pulse generator: bursts of n pulses, or plain blink
`timescale 1ns/1ps
module dse_flasher #(
  parameter int unsigned ON_CYC    = 4000000,
  parameter int unsigned OFF_CYC   = 4000000,
  parameter int unsigned PAUSE_CYC = 20000000
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // pulse count per burst, zero means endless blink
  input  wire logic [2:0] i_pulses,
  // phase output
  output logic            o_phase
);
  logic [24:0] cnt_r;
  logic [2:0]  pulse_r;
  logic        on_r;
  logic        pause_r;
  wire  [24:0] limit;
  wire         done;
  wire         last;

  // segment length selection
  assign limit = pause_r ? 25'(PAUSE_CYC - 1) : (on_r ? 25'(ON_CYC - 1) : 25'(OFF_CYC - 1));
  assign done  = (cnt_r == limit);
  assign last  = (i_pulses != 3'h0) && (pulse_r + 3'h1 >= i_pulses);

  // pulse sequencer
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r   <= 25'h0;
      pulse_r <= 3'h0;
      on_r    <= 1'b1;
      pause_r <= 1'b0;
    end
    else if (done)
    begin
      cnt_r <= 25'h0;
      if (pause_r)
      begin
        pause_r <= 1'b0;
        on_r    <= 1'b1;
        pulse_r <= 3'h0;
      end
      else if (on_r)
        on_r <= 1'b0;
      else if (last)
        pause_r <= 1'b1;
      else
      begin
        on_r    <= 1'b1;
        pulse_r <= pulse_r + 3'h1;
      end
    end
    else
      cnt_r <= cnt_r + 25'h1;
  end

  assign o_phase = on_r & ~pause_r;
endmodule // dse_flasher

// >>> dse_inhibit_timer.sv
// enabling inhibit timer, restarted by each teach or power-up with teach pending
`timescale 1ns/1ps
module dse_inhibit_timer #(
  parameter longint unsigned CYCLES = 64'd12000000000
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // start request
  input  wire logic i_start,
  // running flag
  output logic      o_active
);
  logic [35:0] cnt_r;

  // countdown
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_r <= 36'h0;
    else if (i_start)
      cnt_r <= 36'(CYCLES);
    else if (cnt_r != 36'h0)
      cnt_r <= cnt_r - 36'h1;
  end

  assign o_active = (cnt_r != 36'h0);
endmodule // dse_inhibit_timer

// >>> dse_encoder.sv
// diagnostic status encoder: leds, fault flag, safety code and parameter bits
`timescale 1ns/1ps
// What this block does
// [RULE_01] unsafe error: outputs off, flashing pattern
// [RULE_02] latched error cleared by door open-close
// [RULE_03] open green static zero; closed yellow dynamic
// [RULE_04] limit zone: flash both, fault flag, dynamic
// [RULE_05] inhibit: flash bus led, yellow off, zero
// [RULE_06] device/periphery fault: flash codes, static zero
// [RULE_07] address zero or comms fail: red, zero
// [RULE_08] 4 pulses temp, 5 actuator, steady internal
// [RULE_09] every error except address zero or comms fail raises periphery fault flag
// [RULE_10] fault flag set: bus led flashes red-green
// [RULE_11] parameter write F answers diagnostic bits
// [RULE_12] standard bits: actuator, hysteresis, inhibit, internal
// [RULE_13] identification variant: actuator number or zero
// [RULE_14] inhibit ten minutes after teach, restarts
// [RULE_15] timing parameters; faults override guard indication
module dse_encoder #(
  parameter int unsigned     FLASH_ON_CYC  = dse_pkg::FLASH_ON_CYC,
  parameter int unsigned     FLASH_OFF_CYC = dse_pkg::FLASH_OFF_CYC,
  parameter int unsigned     PAUSE_CYC     = dse_pkg::PAUSE_CYC,
  parameter longint unsigned INHIBIT_CYC   = dse_pkg::INHIBIT_CYC
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // sensor state, from the pins
  input  wire logic       i_act_present,
  input  wire logic       i_act_hyst,
  input  wire logic       i_temp_high,
  input  wire logic       i_act_fault,
  input  wire logic       i_internal_fault,
  input  wire logic       i_periph_fault,
  input  wire logic       i_teach_done,
  input  wire logic       i_teach_pending_pwrup,
  input  wire logic [3:0] i_act_number,
  // bus state, from the pins
  input  wire logic       i_addr_zero,
  input  wire logic       i_comm_fail,
  input  wire logic       i_param_wr,
  input  wire logic [3:0] i_param_val,
  // configuration
  input  wire logic       i_id_variant,
  // dynamic code from the code generator
  input  wire logic [3:0] i_dyn_code,
  // indicator outputs
  output logic [1:0]      o_bicolour_bus_led,
  output logic            o_yellow_led,
  // slave interface outputs
  output logic            o_periphery_fault_flag,
  output logic [3:0]      o_safe_code_word,
  output logic [3:0]      o_diagnostic_param_bits,
  output logic            o_param_ack,
  output logic            o_safety_off,
  output logic            o_error_latched
);
  // two flop synchroniser on all pin inputs
  localparam int unsigned NSYNC = 20;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  wire  [NSYNC-1:0] raw;
  assign raw = {i_act_present, i_act_hyst, i_temp_high, i_act_fault, i_internal_fault,
                i_periph_fault, i_teach_done, i_teach_pending_pwrup, i_act_number,
                i_addr_zero, i_comm_fail, i_param_wr, i_param_val, i_id_variant};

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  wire       act_in    = s2_r[19];
  wire       hyst      = s2_r[18];
  wire       temp_hi   = s2_r[17];
  wire       act_bad   = s2_r[16];
  wire       int_bad   = s2_r[15];
  wire       per_bad   = s2_r[14];
  wire       teach     = s2_r[13];
  wire       pwr_teach = s2_r[12];
  wire [3:0] act_num   = s2_r[11:8];
  wire       addr0     = s2_r[7];
  wire       comm_bad  = s2_r[6];
  wire       pwr       = s2_r[5];
  wire [3:0] pval      = s2_r[4:1];
  wire       idv       = s2_r[0];
  logic [1:0] live_r;  // fills as the synchroniser fills after reset
  logic      pwr_d_r;
  logic      teach_d_r;
  logic      pwrup_seen_r;

  // enabling inhibit: restarts on teach or at power-up with teach pending
  wire inhibit_start;
  wire inhibit_on;
  // [RULE_14] ten minute restart
  assign inhibit_start = (teach & ~teach_d_r) | (pwr_teach & ~pwrup_seen_r);

  dse_inhibit_timer #(
    .CYCLES (INHIBIT_CYC)
  ) u_inhibit (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (inhibit_start),
    .o_active  (inhibit_on)
  );

  // error detection and latch
  wire any_fault;
  wire door_open;
  logic err_r;
  logic saw_open_r;
  assign any_fault = temp_hi | act_bad | int_bad | per_bad;
  assign door_open = ~act_in;

  // [RULE_02] clear only after open then close
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      err_r      <= 1'b0;
      saw_open_r <= 1'b0;
    end
    else if (any_fault)
    begin
      err_r      <= 1'b1;
      saw_open_r <= 1'b0;
    end
    else if (err_r && door_open)
      saw_open_r <= 1'b1;
    else if (err_r && saw_open_r)
    begin
      err_r      <= 1'b0;
      saw_open_r <= 1'b0;
    end
  end

  // state priority: fault over inhibit over limit zone over guard state
  dse_pkg::dse_state_e st;
  // [RULE_15] faults take precedence
  assign st = (any_fault | err_r) ? dse_pkg::ST_FAULT :
              inhibit_on          ? dse_pkg::ST_INHIBIT :
              (act_in & hyst)     ? dse_pkg::ST_HYST :
              act_in              ? dse_pkg::ST_CLOSED : dse_pkg::ST_OPEN;

  // flash code selection for yellow led
  wire [2:0] code_pulses;
  wire       yel_phase;
  wire       blink_phase;
  // [RULE_08] pulse counts per fault
  assign code_pulses = temp_hi ? dse_pkg::CODE_TEMP_PULSES :
                       act_bad ? dse_pkg::CODE_ACT_PULSES : 3'h0;

  dse_flasher #(
    .ON_CYC    (FLASH_ON_CYC),
    .OFF_CYC   (FLASH_OFF_CYC),
    .PAUSE_CYC (PAUSE_CYC)
  ) u_code_flash (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_pulses  (code_pulses),
    .o_phase   (yel_phase)
  );

  dse_flasher #(
    .ON_CYC    (FLASH_ON_CYC),
    .OFF_CYC   (FLASH_OFF_CYC),
    .PAUSE_CYC (PAUSE_CYC)
  ) u_blink (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_pulses  (3'h0),
    .o_phase   (blink_phase)
  );

  // output decode
  logic       fid_nxt;
  logic [1:0] led_nxt;
  logic       yel_nxt;
  logic [3:0] code_nxt;
  logic       off_nxt;

  always_comb
  begin
    fid_nxt  = 1'b0;
    yel_nxt  = 1'b0;
    code_nxt = dse_pkg::CODE_STATIC_ZERO;
    off_nxt  = 1'b1;
    case (st)
      // [RULE_03] guard open
      dse_pkg::ST_OPEN:
        ;
      // [RULE_03] guard closed
      dse_pkg::ST_CLOSED:
      begin
        yel_nxt  = 1'b1;
        code_nxt = i_dyn_code;
        off_nxt  = 1'b0;
      end
      // [RULE_04] limit zone
      dse_pkg::ST_HYST:
      begin
        fid_nxt  = 1'b1;
        yel_nxt  = blink_phase;
        code_nxt = i_dyn_code;
        off_nxt  = 1'b0;
      end
      // [RULE_05] enabling inhibit
      dse_pkg::ST_INHIBIT:
        fid_nxt = 1'b1;
      // [RULE_06] fault flash code, [RULE_01] outputs off
      dse_pkg::ST_FAULT:
      begin
        fid_nxt = 1'b1;
        yel_nxt = int_bad ? 1'b1 : (code_pulses != 3'h0) ? yel_phase : blink_phase;
      end
      default:
        fid_nxt = 1'b1;
    endcase
    // [RULE_07] bus error forces red and clears flag
    if (addr0 | comm_bad)
    begin
      fid_nxt  = 1'b0;
      code_nxt = dse_pkg::CODE_STATIC_ZERO;
      off_nxt  = 1'b1;
    end
  end

  // [RULE_10] flag drives red-green flashing
  assign led_nxt = (addr0 | comm_bad) ? dse_pkg::LED_RED :
                   fid_nxt ? (blink_phase ? dse_pkg::LED_RED : dse_pkg::LED_GREEN) :
                   dse_pkg::LED_GREEN;

  // diagnostic parameter bits
  logic [3:0] pbits;
  always_comb
  begin
    pbits = 4'h0;
    // [RULE_13] actuator number variant
    if (idv)
      pbits = act_in ? act_num : 4'h0;
    else
    begin
      // [RULE_12] standard bit meanings
      pbits[dse_pkg::PB_ACT_IN]  = act_in;
      pbits[dse_pkg::PB_HYST]    = act_in & hyst;
      pbits[dse_pkg::PB_INHIBIT] = inhibit_on;
      pbits[dse_pkg::PB_INT_ERR] = int_bad;
    end
  end

  wire pwr_req = pwr & ~pwr_d_r & (pval == dse_pkg::PARAM_READ_CMD);

  // registered outputs
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bicolour_bus_led      <= dse_pkg::LED_OFF;
      o_yellow_led            <= 1'b0;
      o_periphery_fault_flag  <= 1'b0;
      o_safe_code_word        <= dse_pkg::CODE_STATIC_ZERO;
      o_diagnostic_param_bits <= 4'h0;
      o_param_ack             <= 1'b0;
      o_safety_off            <= 1'b1;
      o_error_latched         <= 1'b0;
      pwr_d_r                 <= 1'b0;
      teach_d_r               <= 1'b0;
      pwrup_seen_r            <= 1'b0;
      live_r                  <= 2'h0;
    end
    else
    begin
      o_bicolour_bus_led     <= led_nxt;
      o_yellow_led           <= yel_nxt;
      // [RULE_09] every error except a bus error raises the flag
      o_periphery_fault_flag <= fid_nxt;
      o_safe_code_word       <= code_nxt;
      o_safety_off           <= off_nxt;
      o_error_latched        <= err_r;
      // [RULE_11] answer parameter write F
      o_param_ack            <= pwr_req;
      if (pwr_req)
        o_diagnostic_param_bits <= pbits;
      pwr_d_r                <= pwr;
      teach_d_r              <= teach;
      // power-up teach flag is only valid once the synchroniser holds pin data
      pwrup_seen_r           <= live_r[1];
      live_r                 <= {live_r[0], 1'b1};
    end
  end

  // fault forces safety off next cycle
  chk_fault_outputs_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (st == dse_pkg::ST_FAULT) |=> o_safety_off && o_safe_code_word == 4'h0) // [RULE_01]
    else $error("fault did not switch outputs off");

  chk_err_hold_closed: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (err_r && !any_fault && !saw_open_r && act_in) |=> err_r) // [RULE_02]
    else $error("error cleared without door open");

  chk_open_static_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (st == dse_pkg::ST_OPEN) |=> !o_yellow_led && o_safe_code_word == 4'h0) // [RULE_03]
    else $error("open guard indication wrong");

  chk_hyst_dynamic: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (st == dse_pkg::ST_HYST && !addr0 && !comm_bad) |=> o_periphery_fault_flag && !o_safety_off) // [RULE_04]
    else $error("limit zone indication wrong");

  chk_inhibit_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (st == dse_pkg::ST_INHIBIT && !addr0 && !comm_bad) |=> !o_yellow_led && o_periphery_fault_flag) // [RULE_05]
    else $error("inhibit indication wrong");

  chk_internal_steady: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    int_bad [*2] |=> o_yellow_led) // [RULE_08]
    else $error("internal fault yellow not steady");

  chk_bus_err_red: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (addr0 || comm_bad) |=> o_bicolour_bus_led == dse_pkg::LED_RED && !o_periphery_fault_flag) // [RULE_07]
    else $error("bus error indication wrong");

  chk_param_answer: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    pwr_req |=> o_param_ack && o_diagnostic_param_bits == $past(pbits)) // [RULE_11]
    else $error("parameter answer wrong");
endmodule // dse_encoder

// >>> dse_bus_master.sv
// bus master model: issues parameter writes and takes the reflected bits
`timescale 1ns/1ps
module dse_bus_master (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // answer from the slave
  input  wire logic       i_param_ack,
  input  wire logic [3:0] i_param_bits,
  // parameter write request
  output logic            o_param_wr,
  output logic [3:0]      o_param_val
);
  // idle request lines
  initial
  begin
    o_param_wr  = 1'b0;
    o_param_val = 4'h0;
  end

  task automatic write_param(input logic [3:0] val, output logic got, output logic [3:0] bits);
    int n;
    got  = 1'b0;
    bits = 4'h0;
    @(posedge i_ref_clk);
    o_param_wr  <= 1'b1;
    o_param_val <= val;
    for (n = 0; n < 12 && got == 1'b0; n++)
    begin
      @(posedge i_ref_clk);
      if (i_param_ack === 1'b1)
      begin
        got  = 1'b1;
        bits = i_param_bits;
      end
    end
    // released value is not left on the lines
    o_param_wr  <= 1'b0;
    o_param_val <= ~val;
    repeat (2) @(posedge i_ref_clk);
  endtask
endmodule // dse_bus_master

// >>> dse_encoder_tb_top.sv
// self-checking bench for the diagnostic status encoder
`timescale 1ns/1ps
module dse_encoder_tb_top;
  // stimulus
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       pres = 1'b0, hyst = 1'b0, temp = 1'b0, actf = 1'b0, intf = 1'b0, perf = 1'b0;
  logic       teach = 1'b0, pend = 1'b0, idv = 1'b0, adr0 = 1'b0, comm = 1'b0;
  logic [3:0] num = 4'h0;
  logic [3:0] dyn = 4'ha;
  // design answers
  logic [1:0] led;
  logic       yel, flag, ack, off, latched, wr, got;
  logic [3:0] code, bits, val, pb;
  // bookkeeping
  int         error_cnt = 0, checked = 0, cycles = 0;
  int         run = 0, max_run = 0, low_cnt = 99, led_tog = 0, low_seen = 0;
  logic       y_q = 1'b0;
  logic [1:0] led_q = 2'h0;

  always #25 clk = ~clk;

  dse_encoder #(.FLASH_ON_CYC(4), .FLASH_OFF_CYC(4), .PAUSE_CYC(16), .INHIBIT_CYC(64'd100)) DUT (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_act_present(pres), .i_act_hyst(hyst), .i_temp_high(temp),
    .i_act_fault(actf), .i_internal_fault(intf), .i_periph_fault(perf), .i_teach_done(teach),
    .i_teach_pending_pwrup(pend), .i_act_number(num), .i_addr_zero(adr0), .i_comm_fail(comm),
    .i_param_wr(wr), .i_param_val(val), .i_id_variant(idv), .i_dyn_code(dyn),
    .o_bicolour_bus_led(led), .o_yellow_led(yel), .o_periphery_fault_flag(flag),
    .o_safe_code_word(code), .o_diagnostic_param_bits(bits), .o_param_ack(ack),
    .o_safety_off(off), .o_error_latched(latched));

  dse_bus_master BM (.i_ref_clk(clk), .i_rst_n(rst_n), .i_param_ack(ack), .i_param_bits(bits),
    .o_param_wr(wr), .o_param_val(val));

  // burst length, blink and led change monitor
  always @(posedge clk)
  begin
    if (yel && !y_q)
      run = (low_cnt <= 8) ? run + 1 : 1;
    if (run > max_run)
      max_run = run;
    low_cnt = yel ? 0 : low_cnt + 1;
    low_seen = yel ? low_seen : low_seen + 1;
    led_tog = (led !== led_q) ? led_tog + 1 : led_tog;
    y_q = yel;
    led_q = led;
  end

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // let the synchroniser and output stage settle
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic mark();
    run = 0;
    max_run = 0;
    led_tog = 0;
    low_seen = 0;
  endtask

  task automatic t_guard();
    @(posedge clk);
    pres <= 1'b0;
    settle();
    check("open led", led, dse_pkg::LED_GREEN);
    check("open yellow", yel, 1'b0);
    check("open flag", flag, 1'b0);
    check("open code", code, dse_pkg::CODE_STATIC_ZERO);
    @(posedge clk);
    pres <= 1'b1;
    settle();
    check("closed yellow", yel, 1'b1);
    check("closed code", code, dyn);
    check("closed safety", off, 1'b0);
    @(posedge clk);
    dyn <= 4'h5;
    repeat (2) @(posedge clk);
    #1;
    check("closed code change", code, 4'h5);
    BM.write_param(dse_pkg::PARAM_READ_CMD, got, pb);
    check("read ack", got, 1'b1);
    check("std bits", pb, 4'h1);
    BM.write_param(4'h7, got, pb);
    check("other value ack", got, 1'b0);
    $display("test guard done");
  endtask

  task automatic t_hyst();
    @(posedge clk);
    hyst <= 1'b1;
    settle();
    mark();
    repeat (100) @(posedge clk);
    check("hyst flag", flag, 1'b1);
    check("hyst code", code, dyn);
    check("hyst led blink", led_tog > 4, 1'b1);
    check("hyst yellow blink", max_run > 1, 1'b1);
    BM.write_param(dse_pkg::PARAM_READ_CMD, got, pb);
    check("hyst bits", pb, 4'h3);
    @(posedge clk);
    hyst <= 1'b0;
    settle();
    $display("test hysteresis done");
  endtask

  task automatic t_bus();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      adr0 <= (i == 0);
      comm <= (i == 1);
      settle();
      check("bus err led", led, dse_pkg::LED_RED);
      check("bus err flag", flag, 1'b0);
      check("bus err code", code, dse_pkg::CODE_STATIC_ZERO);
    end
    @(posedge clk);
    comm <= 1'b0;
    settle();
    $display("test bus error done");
  endtask

  task automatic t_faults();
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      temp <= (k == 0);
      actf <= (k == 1);
      intf <= (k == 2);
      perf <= (k == 3);
      settle();
      mark();
      repeat (150) @(posedge clk);
      check("fault flag", flag, 1'b1);
      check("fault code", code, dse_pkg::CODE_STATIC_ZERO);
      check("fault off", off, 1'b1);
      check("fault led blink", led_tog > 4, 1'b1);
      if (k < 2)
        check("burst pulses", max_run[7:0], (k == 0) ? dse_pkg::CODE_TEMP_PULSES : dse_pkg::CODE_ACT_PULSES);
      if (k == 2)
        check("steady yellow low", low_seen[7:0], 8'h0);
      BM.write_param(dse_pkg::PARAM_READ_CMD, got, pb);
      check("internal bit", pb[3], k == 2);
      @(posedge clk);
      {temp, actf, intf, perf} <= 4'h0;
      settle();
      check("still latched", latched, 1'b1);
      check("still off", off, 1'b1);
      @(posedge clk);
      pres <= 1'b0;
      settle();
      @(posedge clk);
      pres <= 1'b1;
      settle();
      check("latch cleared", latched, 1'b0);
      check("outputs back", off, 1'b0);
    end
    $display("test faults done");
  endtask

  task automatic t_inhibit();
    @(posedge clk);
    teach <= 1'b1;
    settle();
    mark();
    repeat (20) @(posedge clk);
    check("inhibit flag", flag, 1'b1);
    check("inhibit yellow", yel, 1'b0);
    check("inhibit code", code, dse_pkg::CODE_STATIC_ZERO);
    check("inhibit led blink", led_tog > 2, 1'b1);
    BM.write_param(dse_pkg::PARAM_READ_CMD, got, pb);
    check("inhibit bit", pb[2], 1'b1);
    teach <= 1'b0;
    repeat (120) @(posedge clk);
    check("inhibit over", flag, 1'b0);
    check("inhibit over code", code, dyn);
    rst_n <= 1'b0;
    pend <= 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    check("restart inhibit", flag, 1'b1);
    @(posedge clk);
    pend <= 1'b0;
    repeat (130) @(posedge clk);
    check("restart over", flag, 1'b0);
    $display("test inhibit done");
  endtask

  task automatic t_ident();
    @(posedge clk);
    idv <= 1'b1;
    num <= 4'hb;
    settle();
    BM.write_param(dse_pkg::PARAM_READ_CMD, got, pb);
    check("actuator number", pb, 4'hb);
    pres <= 1'b0;
    settle();
    BM.write_param(dse_pkg::PARAM_READ_CMD, got, pb);
    check("no actuator", pb, 4'h0);
    $display("test identification done");
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_guard();
    t_hyst();
    t_bus();
    t_faults();
    t_inhibit();
    t_ident();
    print_verdict();
  end
endmodule // dse_encoder_tb_top
